/* hdl/ccp_pkg.sv */
// Register map, field positions and carrier types of the compare/PWM unit
package ccp_pkg;
  localparam int unsigned UNITS = 3;
  localparam int unsigned AW    = 12;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IX_FLAGS1 = 8'h0c;
  localparam logic [7:0] IX_FLAGS2 = 8'h0d;
  localparam logic [7:0] IX_T1L    = 8'h0e;
  localparam logic [7:0] IX_T1H    = 8'h0f;
  localparam logic [7:0] IX_TIMER_ONE_CONTROL  = 8'h10;
  localparam logic [7:0] IX_T2CNT  = 8'h11;
  localparam logic [7:0] IX_T2CON  = 8'h12;
  localparam logic [7:0] IX_ADC    = 8'h1f;
  localparam logic [7:0] IX_TRIS   = 8'h87;
  localparam logic [7:0] IX_EN1    = 8'h8c;
  localparam logic [7:0] IX_EN2    = 8'h8d;
  localparam logic [7:0] IX_PR2    = 8'h92;
  localparam logic [UNITS-1:0][7:0] IX_MLO = {8'h95, 8'h1b, 8'h15};
  localparam logic [UNITS-1:0][7:0] IX_MHI = {8'h96, 8'h1c, 8'h16};
  localparam logic [UNITS-1:0][7:0] IX_CTL = {8'h97, 8'h1d, 8'h17};

  // Writable bits; unimplemented bits read as zero
  localparam logic [7:0] MASK_ALL  = 8'hff;
  localparam logic [7:0] MASK_F2   = 8'heb;
  localparam logic [7:0] MASK_TCON = 8'h7f;
  localparam logic [7:0] MASK_CTL  = 8'h3f;

  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TRIS = 8'hff;
  localparam logic [7:0] RST_PR2  = 8'hff;

  // Field positions
  localparam int unsigned F1_T1OVF = 0;
  localparam int unsigned F1_T2    = 1;
  localparam int unsigned F1_U1    = 2;
  localparam int unsigned F2_U2    = 0;
  localparam int unsigned F2_U3    = 1;
  localparam int unsigned T1_ON    = 0;
  localparam int unsigned T1_PS    = 4;
  localparam int unsigned T2_PS    = 0;
  localparam int unsigned T2_ON    = 2;
  localparam int unsigned T2_POST  = 3;
  localparam int unsigned ADC_ON   = 0;
  localparam int unsigned ADC_GO   = 2;
  localparam int unsigned CTL_DUTY = 4;
  localparam logic [UNITS-1:0][2:0] PIN_BIT = {3'h3, 3'h1, 3'h2};

  // Mode select codes
  localparam logic [3:0] MODE_OFF  = 4'h0;
  localparam logic [3:0] MODE_SET  = 4'h8;
  localparam logic [3:0] MODE_CLR  = 4'h9;
  localparam logic [3:0] MODE_SWI  = 4'ha;
  localparam logic [3:0] MODE_TRIG = 4'hb;
  localparam logic [1:0] GRP_CMP   = 2'h2;
  localparam logic [1:0] GRP_PWM   = 2'h3;

  // Four oscillator periods per instruction cycle
  localparam logic [1:0]  Q_LAST = 2'h3;
  localparam logic [15:0] T1_MAX = 16'hffff;

  typedef struct packed {
    logic       t1_tick;
    logic       t2_tick;
    logic [1:0] fine;
  } ccp_tbase_t;

  typedef struct packed {
    logic [3:0] mode;
    logic [1:0] duty_lo;
    logic [7:0] match_lo;
    logic [7:0] match_hi;
  } ccp_cfg_t;
endpackage

/* hdl/ccp_timebase.sv */
// Instruction-cycle phase and timer prescalers
`timescale 1ns/100ps
`default_nettype none
module ccp_timebase (
  input  wire logic             pclk,    // Oscillator clock
  input  wire logic             presetn, // Async reset, active low
  input  wire logic             t1_on,   // Timer1 running
  input  wire logic [1:0]       t1_ps,   // Timer1 prescale code
  input  wire logic             t2_on,   // Timer2 running
  input  wire logic [1:0]       t2_ps,   // Timer2 prescale code
  output ccp_pkg::ccp_tbase_t   tb       // Increment enables, fine phase
);
  typedef struct packed {
    logic [1:0] q;
    logic [2:0] p1;
    logic [3:0] p2;
  } ccp_tbs_t;

  ccp_tbs_t   st_r;
  ccp_tbs_t   st_nxt;
  logic       qend;
  logic       p2end;
  logic [2:0] m1;

  always_comb begin
    st_nxt = st_r;
    qend   = st_r.q == ccp_pkg::Q_LAST;
    st_nxt.q = st_r.q + 2'h1;
    if (qend && t1_on) begin
      st_nxt.p1 = st_r.p1 + 3'h1;
    end
    if (qend && t2_on) begin
      st_nxt.p2 = st_r.p2 + 4'h1;
    end
    unique case (t1_ps)
      2'h0: m1 = 3'h0;
      2'h1: m1 = 3'h1;
      2'h2: m1 = 3'h3;
      default: m1 = 3'h7;
    endcase
    // Fine phase extends timer2 to ten bits for the duty compare
    unique case (t2_ps)
      2'h0: begin
        p2end   = 1'b1;
        tb.fine = st_r.q;
      end
      2'h1: begin
        p2end   = st_r.p2[1:0] == 2'h3;
        tb.fine = st_r.p2[1:0];
      end
      default: begin
        p2end   = st_r.p2 == 4'hf;
        tb.fine = st_r.p2[3:2];
      end
    endcase
    tb.t1_tick = qend && t1_on && ((st_r.p1 & m1) == m1);
    tb.t2_tick = qend && t2_on && p2end;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

/* hdl/ccp_top.sv */
// APB register file, timers and three compare/PWM units
`timescale 1ns/100ps
`default_nettype none
module ccp_top (
  input  wire logic                    pclk,       // Clock, 250 MHz
  input  wire logic                    presetn,    // Async reset, low
  input  wire logic                    psel,       // APB select
  input  wire logic                    penable,    // APB enable
  input  wire logic                    pwrite,     // APB direction
  input  wire logic [ccp_pkg::AW-1:0]  paddr,      // APB byte address
  input  wire logic [31:0]             pwdata,     // APB write data
  output logic      [31:0]             prdata,     // APB read data
  output logic                         pready,     // APB ready
  output logic                         pslverr,    // APB error
  output logic      [ccp_pkg::UNITS-1:0] unit_pin_o,    // Pin level
  output logic      [ccp_pkg::UNITS-1:0] unit_pin_oe_n, // Drive, low
  output logic                         conv_go     // Converter start
);
  localparam int unsigned N = ccp_pkg::UNITS;

  typedef struct packed {
    logic [7:0]         flags1;
    logic [7:0]         flags2;
    logic [7:0]         en1;
    logic [7:0]         en2;
    logic [15:0]        timer_one_count;
    logic [7:0]         timer_one_control;
    logic [7:0]         timer_two_count;
    logic [7:0]         pr2;
    logic [7:0]         t2con;
    logic [3:0]         post;
    logic [7:0]         tris;
    logic [7:0]         adc;
    logic [N-1:0][7:0]  mlo;
    logic [N-1:0][7:0]  mhi;
    logic [N-1:0][7:0]  ctl;
    logic [N-1:0]       pin;
    logic [N-1:0]       oe_n;
    logic [31:0]        rdata;
    logic               rdy;
    logic               err;
  } ccp_top_st_t;

  ccp_top_st_t                 st_r;
  ccp_top_st_t                 st_nxt;
  ccp_pkg::ccp_tbase_t         tb;
  ccp_pkg::ccp_cfg_t [N-1:0]   cfg;
  logic [N-1:0]                upin;
  logic [N-1:0]                uevt;
  logic [N-1:0]                utrig;
  logic [N-1:0][7:0]           ubuf;

  ccp_timebase u_tbase (
    .pclk    (pclk),
    .presetn (presetn),
    .t1_on   (st_r.timer_one_control[ccp_pkg::T1_ON]),
    .t1_ps   (st_r.timer_one_control[ccp_pkg::T1_PS +: 2]),
    .t2_on   (st_r.t2con[ccp_pkg::T2_ON]),
    .t2_ps   (st_r.t2con[ccp_pkg::T2_PS +: 2]),
    .tb      (tb)
  );

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_unit
      assign cfg[gi].mode     = st_r.ctl[gi][3:0];
      assign cfg[gi].duty_lo  = st_r.ctl[gi][ccp_pkg::CTL_DUTY +: 2];
      assign cfg[gi].match_lo = st_r.mlo[gi];
      assign cfg[gi].match_hi = st_r.mhi[gi];
      // Only units 1 and 2 own a special event trigger
      ccp_unit #(
        .HAS_TRIG (gi < 2)
      ) u_unit (
        .pclk     (pclk),
        .presetn  (presetn),
        .cfg      (cfg[gi]),
        .timer_one_count     (st_r.timer_one_count),
        .timer_two_count     (st_r.timer_two_count),
        .pr2      (st_r.pr2),
        .tb       (tb),
        .pin      (upin[gi]),
        .event_p  (uevt[gi]),
        .trig_p   (utrig[gi]),
        .duty_buf (ubuf[gi])
      );
    end
  endgenerate

  always_comb begin
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic       hit;
    logic       setup;
    logic       wr;
    logic       t2_wrap;
    idx     = 8'h00;
    wd      = 8'h00;
    rd      = 8'h00;
    hit     = 1'b1;
    setup   = 1'b0;
    wr      = 1'b0;
    t2_wrap = 1'b0;
    st_nxt  = st_r;

    idx   = paddr[9:2];
    wd    = pwdata[7:0];
    setup = psel && !penable;
    // A write lands only at the single access edge with ready high
    wr    = psel && penable && pwrite && st_r.rdy && !st_r.err;

    // Read decode
    unique case (idx)
      ccp_pkg::IX_FLAGS1: rd = st_r.flags1;
      ccp_pkg::IX_FLAGS2: rd = st_r.flags2;
      ccp_pkg::IX_EN1:    rd = st_r.en1;
      ccp_pkg::IX_EN2:    rd = st_r.en2;
      ccp_pkg::IX_T1L:    rd = st_r.timer_one_count[7:0];
      ccp_pkg::IX_T1H:    rd = st_r.timer_one_count[15:8];
      ccp_pkg::IX_TIMER_ONE_CONTROL:  rd = st_r.timer_one_control;
      ccp_pkg::IX_T2CNT:  rd = st_r.timer_two_count;
      ccp_pkg::IX_PR2:    rd = st_r.pr2;
      ccp_pkg::IX_T2CON:  rd = st_r.t2con;
      ccp_pkg::IX_TRIS:   rd = st_r.tris;
      ccp_pkg::IX_ADC:    rd = st_r.adc;
      default:            hit = 1'b0;
    endcase
    for (int i = 0; i < N; i++) begin
      if (idx == ccp_pkg::IX_MLO[i]) begin
        rd  = st_r.mlo[i];
        hit = 1'b1;
      end
      if (idx == ccp_pkg::IX_MHI[i]) begin
        // In PWM mode the high byte shows the live duty buffer
        rd  = (st_r.ctl[i][3:2] == ccp_pkg::GRP_PWM) ? ubuf[i]
                                                     : st_r.mhi[i];
        hit = 1'b1;
      end
      if (idx == ccp_pkg::IX_CTL[i]) begin
        rd  = st_r.ctl[i];
        hit = 1'b1;
      end
    end
    if (paddr[ccp_pkg::AW-1:10] != '0) begin
      hit = 1'b0;
    end

    // Bus handshake: setup cycle loads the answer, one access cycle
    if (setup) begin
      st_nxt.rdy   = 1'b1;
      st_nxt.err   = !hit;
      st_nxt.rdata = (hit && !pwrite) ? {24'h000000, rd} : 32'h00000000;
    end else if (psel && penable && st_r.rdy) begin
      st_nxt.rdy = 1'b0;
      st_nxt.err = 1'b0;
    end

    // Timer1 increment, then software write, then special event clear
    if (tb.t1_tick) begin
      st_nxt.timer_one_count = st_r.timer_one_count + 16'h0001;
    end
    if (wr && idx == ccp_pkg::IX_T1L) begin
      st_nxt.timer_one_count[7:0] = wd;
    end
    if (wr && idx == ccp_pkg::IX_T1H) begin
      st_nxt.timer_one_count[15:8] = wd;
    end
    if (utrig[0] || utrig[1]) begin
      st_nxt.timer_one_count = 16'h0000;
    end

    // Timer2 wraps after matching its period, giving the PWM period
    if (tb.t2_tick) begin
      if (st_r.timer_two_count == st_r.pr2) begin
        st_nxt.timer_two_count = 8'h00;
        t2_wrap     = 1'b1;
      end else begin
        st_nxt.timer_two_count = st_r.timer_two_count + 8'h01;
      end
    end
    if (wr && idx == ccp_pkg::IX_T2CNT) begin
      st_nxt.timer_two_count = wd;
    end
    // Postscaler counts periods for the flag only
    if (t2_wrap) begin
      if (st_r.post == st_r.t2con[ccp_pkg::T2_POST +: 4]) begin
        st_nxt.post = 4'h0;
      end else begin
        st_nxt.post = st_r.post + 4'h1;
      end
    end

    // Plain register writes
    if (wr) begin
      unique case (idx)
        ccp_pkg::IX_FLAGS1: st_nxt.flags1 = wd & ccp_pkg::MASK_ALL;
        ccp_pkg::IX_FLAGS2: st_nxt.flags2 = wd & ccp_pkg::MASK_F2;
        ccp_pkg::IX_EN1:    st_nxt.en1    = wd & ccp_pkg::MASK_ALL;
        ccp_pkg::IX_EN2:    st_nxt.en2    = wd & ccp_pkg::MASK_F2;
        ccp_pkg::IX_TIMER_ONE_CONTROL:  st_nxt.timer_one_control  = wd & ccp_pkg::MASK_TCON;
        ccp_pkg::IX_PR2:    st_nxt.pr2    = wd;
        ccp_pkg::IX_T2CON:  st_nxt.t2con  = wd & ccp_pkg::MASK_TCON;
        ccp_pkg::IX_TRIS:   st_nxt.tris   = wd;
        ccp_pkg::IX_ADC:    st_nxt.adc    = wd;
        default: ;
      endcase
      for (int i = 0; i < N; i++) begin
        if (idx == ccp_pkg::IX_MLO[i]) begin
          st_nxt.mlo[i] = wd;
        end
        // High byte is read-only while the unit runs PWM
        if (idx == ccp_pkg::IX_MHI[i]
            && st_r.ctl[i][3:2] != ccp_pkg::GRP_PWM) begin
          st_nxt.mhi[i] = wd;
        end
        if (idx == ccp_pkg::IX_CTL[i]) begin
          st_nxt.ctl[i] = wd & ccp_pkg::MASK_CTL;
        end
      end
    end

    // Hardware sets win over a software clear in the same cycle
    if (uevt[0]) begin
      st_nxt.flags1[ccp_pkg::F1_U1] = 1'b1;
    end
    if (uevt[1]) begin
      st_nxt.flags2[ccp_pkg::F2_U2] = 1'b1;
    end
    if (uevt[2]) begin
      st_nxt.flags2[ccp_pkg::F2_U3] = 1'b1;
    end
    if (tb.t1_tick && st_r.timer_one_count == ccp_pkg::T1_MAX
        && !(utrig[0] || utrig[1])) begin
      st_nxt.flags1[ccp_pkg::F1_T1OVF] = 1'b1;
    end
    if (t2_wrap && st_r.post == st_r.t2con[ccp_pkg::T2_POST +: 4]) begin
      st_nxt.flags1[ccp_pkg::F1_T2] = 1'b1;
    end
    if (utrig[1] && st_r.adc[ccp_pkg::ADC_ON]) begin
      st_nxt.adc[ccp_pkg::ADC_GO] = 1'b1;
    end

    // Pin stage; direction bit low lets the unit drive the pin
    for (int i = 0; i < N; i++) begin
      st_nxt.pin[i]  = upin[i];
      st_nxt.oe_n[i] = st_r.tris[ccp_pkg::PIN_BIT[i]];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r       <= '0;
      st_r.tris  <= ccp_pkg::RST_TRIS;
      st_r.pr2   <= ccp_pkg::RST_PR2;
      st_r.oe_n  <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata        = st_r.rdata;
  assign pready        = st_r.rdy;
  assign pslverr       = st_r.err;
  assign unit_pin_o    = st_r.pin;
  assign unit_pin_oe_n = st_r.oe_n;
  assign conv_go       = st_r.adc[ccp_pkg::ADC_GO];
endmodule
`default_nettype wire

/* hdl/ccp_unit.sv */
// One compare/PWM unit: match detection, output latch, duty buffer
`timescale 1ns/100ps
`default_nettype none
module ccp_unit #(
  parameter logic HAS_TRIG = 1'b1
) (
  input  wire logic                pclk,     // Oscillator clock
  input  wire logic                presetn,  // Async reset, active low
  input  wire ccp_pkg::ccp_cfg_t   cfg,      // Mode, duty and match
  input  wire logic [15:0]         timer_one_count,     // Timer1 count
  input  wire logic [7:0]          timer_two_count,     // Timer2 count
  input  wire logic [7:0]          pr2,      // Timer2 period
  input  wire ccp_pkg::ccp_tbase_t tb,       // Time base
  output logic                     pin,      // Output latch
  output logic                     event_p,  // Compare event pulse
  output logic                     trig_p,   // Special event pulse
  output logic [7:0]               duty_buf  // Buffered duty, high part
);
  typedef struct packed {
    logic       prev_eq;
    logic       wrap;
    logic       pin;
    logic [7:0] buf_hi;
    logic [1:0] buf_lo;
  } ccp_us_t;

  ccp_us_t st_r;
  ccp_us_t st_nxt;
  logic    eq;
  logic    is_cmp;
  logic    is_pwm;

  always_comb begin
    st_nxt = st_r;
    eq     = timer_one_count == {cfg.match_hi, cfg.match_lo};
    is_cmp = cfg.mode[3:2] == ccp_pkg::GRP_CMP;
    is_pwm = cfg.mode[3:2] == ccp_pkg::GRP_PWM;
    st_nxt.prev_eq = eq;
    st_nxt.wrap    = is_pwm && tb.t2_tick && timer_two_count == pr2;
    // Acts on entry into equality only, so a stopped timer fires once
    event_p = is_cmp && eq && !st_r.prev_eq;
    trig_p  = event_p && HAS_TRIG
              && cfg.mode == ccp_pkg::MODE_TRIG;
    if (cfg.mode == ccp_pkg::MODE_OFF) begin
      st_nxt.pin = 1'b0;
    end else if (event_p) begin
      if (cfg.mode == ccp_pkg::MODE_SET) begin
        st_nxt.pin = 1'b1;
      end else if (cfg.mode == ccp_pkg::MODE_CLR) begin
        st_nxt.pin = 1'b0;
      end
    end else if (is_pwm) begin
      // Period start is registered so set and clear share one latency
      if (st_r.wrap) begin
        st_nxt.pin    = {cfg.match_lo, cfg.duty_lo} != '0;
        st_nxt.buf_hi = cfg.match_lo;
        st_nxt.buf_lo = cfg.duty_lo;
      end else if ({st_r.buf_hi, st_r.buf_lo}
                   == {timer_two_count, tb.fine}) begin
        // A duty longer than the period never clears the pin
        st_nxt.pin = 1'b0;
      end
    end
    pin      = st_r.pin;
    duty_buf = st_r.buf_hi;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

/* tb/ccp_compare_and_pwm_test.sv */
// Self-checking bench for the compare/PWM unit
`timescale 1ns/100ps
`default_nettype none
module ccp_compare_and_pwm_test;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  unit_pin_o;
  logic [2:0]  unit_pin_oe_n;
  logic        conv_go;
  logic        ld_level;
  logic [31:0] ld_rises;
  logic [31:0] ld_period;
  logic [31:0] ld_high;
  int          err_total;
  int          samples_checked;
  logic [16:0] notes[$];
  logic [16:0] note;
  logic [1:0]  code;
  logic [7:0]  pr;
  logic [9:0]  duty;
  int          ps;
  logic [7:0]  rst_ix[7] = '{ccp_pkg::IX_TRIS, ccp_pkg::IX_PR2,
    ccp_pkg::IX_CTL[0], ccp_pkg::IX_CTL[1], ccp_pkg::IX_CTL[2],
    ccp_pkg::IX_FLAGS1, ccp_pkg::IX_FLAGS2};
  logic [7:0]  rst_v[7] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  ccp_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .unit_pin_o(unit_pin_o),
    .unit_pin_oe_n(unit_pin_oe_n), .conv_go(conv_go));
  ccp_load i_load (
    .pclk(pclk), .presetn(presetn), .drive_lvl(unit_pin_o[0]),
    .drive_oe_n(unit_pin_oe_n[0]), .level(ld_level), .rises(ld_rises),
    .period(ld_period), .high_time(ld_high));

  always #2 pclk = ~pclk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request held until pready is sampled high, then released
  task automatic xfer(input logic [7:0] ix, input logic wr,
                      input logic [7:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'h0, ix, 2'h0};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    xfer(ix, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] ix, input logic [7:0] m,
                    input logic [7:0] e, input logic err = 1'b0);
    notes.push_back({err, m, e});
    xfer(ix, 1'b0, 8'h00);
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && notes.size() > 0) begin
      note = notes.pop_front();
      check("read data", prdata[7:0] & note[15:8], note[7:0] & note[15:8]);
      check("read error", pslverr, note[16]);
    end
  end

  task automatic wait_rises(input int n);
    int k;
    logic [31:0] s;
    s = ld_rises;
    k = 0;
    while (ld_rises < s + n && k < 20000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 20000) begin
      err_total++;
      report_and_stop();
    end
  endtask

  // Match sits above 256 so a missed timer clear shows in the high byte
  task automatic cmp_run(input int u, input logic [3:0] mode);
    logic [15:0] m;
    logic [7:0]  fx;
    logic [7:0]  fb;
    m = 16'h0110 + 16'($urandom % 16);
    fx = (u == 0) ? ccp_pkg::IX_FLAGS1 : ccp_pkg::IX_FLAGS2;
    fb = (u == 0) ? 8'h04 : (u == 1) ? 8'h01 : 8'h02;
    wr(fx, 8'h00);
    wr(ccp_pkg::IX_MLO[u], m[7:0]);
    wr(ccp_pkg::IX_MHI[u], m[15:8]);
    wr(ccp_pkg::IX_T1H, 8'h00);
    wr(ccp_pkg::IX_T1L, 8'h00);
    wr(ccp_pkg::IX_CTL[u], {4'h0, mode});
    repeat ((int'(m) + 6) * 4) @(posedge pclk);
    rd(fx, fb, fb);
    rd(ccp_pkg::IX_T1H, 8'hff,
       (mode == ccp_pkg::MODE_TRIG && u < 2) ? 8'h00 : 8'h01);
    if (u == 0)
      rd(ccp_pkg::IX_FLAGS1, 8'h01, 8'h00);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    err_total = 0;
    samples_checked = 0;
    void'($urandom(32'ha4d918f0));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("idle load", ld_level, 1'b0);
    for (int i = 0; i < 7; i++)
      rd(rst_ix[i], 8'hff, rst_v[i]);
    rd(8'h40, 8'hff, 8'h00, 1'b1);
    wr(ccp_pkg::IX_FLAGS2, 8'hff);
    rd(ccp_pkg::IX_FLAGS2, 8'hff, ccp_pkg::MASK_F2);
    wr(ccp_pkg::IX_FLAGS2, 8'h00);
    $display("test registers done");
    wr(ccp_pkg::IX_TIMER_ONE_CONTROL, 8'h01);
    wr(ccp_pkg::IX_TRIS, 8'hf1);
    cmp_run(0, ccp_pkg::MODE_SET);
    check("pin set", ld_level, 1'b1);
    cmp_run(0, ccp_pkg::MODE_SWI);
    check("pin kept", ld_level, 1'b1);
    cmp_run(0, ccp_pkg::MODE_CLR);
    check("pin cleared", ld_level, 1'b0);
    cmp_run(0, ccp_pkg::MODE_SET);
    wr(ccp_pkg::IX_FLAGS1, 8'h00);
    repeat (40) @(posedge pclk);
    rd(ccp_pkg::IX_FLAGS1, 8'h04, 8'h00);
    wr(ccp_pkg::IX_CTL[0], 8'h00);
    repeat (4) @(posedge pclk);
    check("pin after clear", ld_level, 1'b0);
    // Trigger at the top count must clear timer1 before it overflows
    wr(ccp_pkg::IX_FLAGS1, 8'h00);
    wr(ccp_pkg::IX_MLO[0], 8'hff);
    wr(ccp_pkg::IX_MHI[0], 8'hff);
    wr(ccp_pkg::IX_T1H, 8'hff);
    wr(ccp_pkg::IX_T1L, 8'hf0);
    wr(ccp_pkg::IX_CTL[0], {4'h0, ccp_pkg::MODE_TRIG});
    repeat (100) @(posedge pclk);
    rd(ccp_pkg::IX_FLAGS1, 8'h05, 8'h04);
    rd(ccp_pkg::IX_T1H, 8'hff, 8'h00);
    wr(ccp_pkg::IX_CTL[0], 8'h00);
    wr(ccp_pkg::IX_TIMER_ONE_CONTROL, 8'h31);
    wr(ccp_pkg::IX_T1L, 8'h00);
    repeat (320) @(posedge pclk);
    rd(ccp_pkg::IX_T1L, 8'hf8, 8'h08);
    wr(ccp_pkg::IX_TIMER_ONE_CONTROL, 8'h01);
    $display("test compare done");
    for (int en = 0; en < 2; en++) begin
      wr(ccp_pkg::IX_ADC, 8'(en));
      cmp_run(1, ccp_pkg::MODE_TRIG);
      check("go bit", conv_go, 32'(en));
      wr(ccp_pkg::IX_ADC, 8'h00);
    end
    cmp_run(1, ccp_pkg::MODE_SET);
    check("unit2 pin", unit_pin_o[1], 1'b1);
    wr(ccp_pkg::IX_CTL[1], 8'h00);
    cmp_run(2, ccp_pkg::MODE_TRIG);
    cmp_run(2, ccp_pkg::MODE_SET);
    check("unit3 pin", unit_pin_o[2], 1'b1);
    wr(ccp_pkg::IX_CTL[2], 8'hff);
    rd(ccp_pkg::IX_CTL[2], 8'hff, ccp_pkg::MASK_CTL);
    wr(ccp_pkg::IX_CTL[2], 8'h00);
    repeat (4) @(posedge pclk);
    check("unit3 clear", unit_pin_o[2], 1'b0);
    $display("test trigger done");
    for (int i = 0; i < 4; i++) begin
      code = (i == 3) ? 2'h0 : 2'(i);
      pr = (i == 1) ? 8'h04 : 8'h09;
      duty = (i == 0) ? 10'(1 + $urandom % 38) : (i == 1) ? 10'd7
             : (i == 2) ? 10'h01d : 10'd0;
      ps = (code == 2'h0) ? 1 : (code == 2'h1) ? 4 : 16;
      wr(ccp_pkg::IX_CTL[0], 8'h00);
      wr(ccp_pkg::IX_PR2, pr);
      wr(ccp_pkg::IX_MLO[0], duty[9:2]);
      wr(ccp_pkg::IX_T2CON, {1'b0, 4'($urandom % 16), 1'b1, code});
      wr(ccp_pkg::IX_CTL[0], {2'h0, duty[1:0], 4'hc});
      if (duty == 10'd0) begin
        repeat ((int'(pr) + 1) * 16 * ps) @(posedge pclk);
        check("pwm idle", ld_level, 1'b0);
      end else begin
        wait_rises(3);
        check("pwm period", ld_period, (int'(pr) + 1) * 4 * ps);
        check("pwm high", ld_high, int'(duty) * ps);
      end
      rd(ccp_pkg::IX_MHI[0], 8'hff, duty[9:2]);
      wr(ccp_pkg::IX_MHI[0], 8'h5a);
      rd(ccp_pkg::IX_MHI[0], 8'hff, duty[9:2]);
    end
    $display("test pwm done");
    report_and_stop();
  end
endmodule
`default_nettype wire

/* tb/ccp_load.sv */
// Pulled-down load on one unit pin that times its pulses
`timescale 1ns/100ps
`default_nettype none
module ccp_load (
  input  wire logic        pclk,       // Clock
  input  wire logic        presetn,    // Reset, low
  input  wire logic        drive_lvl,  // Unit output latch
  input  wire logic        drive_oe_n, // Unit drives, low
  output logic             level,      // Wire level
  output logic [31:0]      rises,      // Rising edges seen
  output logic [31:0]      period,     // Last rise to rise
  output logic [31:0]      high_time   // Last high time
);
  logic        prev;
  logic [31:0] cnt;
  // Pull-down: an undriven pin reads low, never the last value
  assign level = drive_oe_n ? 1'b0 : drive_lvl;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev      <= 1'b0;
      cnt       <= 32'h0;
      rises     <= 32'h0;
      period    <= 32'h0;
      high_time <= 32'h0;
    end else begin
      prev <= level;
      cnt  <= cnt + 32'h1;
      if (level && !prev) begin
        rises  <= rises + 32'h1;
        period <= cnt;
        cnt    <= 32'h1;
      end
      if (!level && prev)
        high_time <= cnt;
    end
  end
endmodule
`default_nettype wire

/* tb/ccp_top_chk.sv */
// Bus and pin checker bound to the compare/PWM top
`timescale 1ns/100ps
`default_nettype none
module ccp_top_chk (
  input wire logic                      pclk,          // Clock
  input wire logic                      presetn,       // Reset, low
  input wire logic                      psel,          // Select
  input wire logic                      penable,       // Enable
  input wire logic                      pwrite,        // Direction
  input wire logic [ccp_pkg::AW-1:0]    paddr,         // Byte address
  input wire logic [31:0]               pwdata,        // Write data
  input wire logic [31:0]               prdata,        // Read data
  input wire logic                      pready,        // Ready
  input wire logic                      pslverr,       // Error
  input wire logic [ccp_pkg::UNITS-1:0] unit_pin_o,    // Pin levels
  input wire logic [ccp_pkg::UNITS-1:0] unit_pin_oe_n, // Drive, low
  input wire logic                      conv_go        // Go bit
);
  logic       wr_acc;
  logic       wr_adc;
  logic [7:0] tris_r;
  logic [7:0] adc_r;
  assign wr_acc = psel && penable && pready && pwrite;
  assign wr_adc = wr_acc && paddr[9:2] == ccp_pkg::IX_ADC;
  // Shadows of the registers whose effect shows at the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tris_r <= 8'hff;
      adc_r  <= 8'h00;
    end else begin
      if (wr_acc && paddr[9:2] == ccp_pkg::IX_TRIS)
        tris_r <= pwdata[7:0];
      if (wr_adc)
        adc_r <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_no_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  read_upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  dir_readback_a: assert property (pready && !pwrite &&
    paddr[9:2] == ccp_pkg::IX_TRIS |-> prdata[7:0] == tris_r)
    else $error("direction readback wrong");
  drive_follows_dir_a: assert property (unit_pin_oe_n ==
    {$past(tris_r[3]), $past(tris_r[1]), $past(tris_r[2])})
    else $error("pin drive does not follow direction");
  clear_forces_low_a: assert property (wr_acc &&
    paddr[9:2] == ccp_pkg::IX_CTL[0] && pwdata[7:0] == 8'h00
    |-> ##[1:3] !unit_pin_o[0])
    else $error("control clear left pin high");
  go_needs_enable_a: assert property ($rose(conv_go) |->
    adc_r[ccp_pkg::ADC_ON] || $past(wr_adc) || $past(wr_adc, 2))
    else $error("go bit set while converter off");
  go_sw_clear_a: assert property ($fell(conv_go) |->
    $past(wr_adc) || $past(wr_adc, 2))
    else $error("go bit cleared without write");
  cover property ($rose(unit_pin_o[0]));
  cover property ($rose(conv_go));
  cover property (pslverr);
endmodule
bind ccp_top ccp_top_chk i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .unit_pin_o(unit_pin_o),
  .unit_pin_oe_n(unit_pin_oe_n), .conv_go(conv_go)
);
`default_nettype wire
